/* dv/dsd_decode_unit_tb_top.sv */
// Self-checking bench for the DSP-support decode unit
`timescale 1ns/10ps
`define CHK(g, e) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      mismatches++; \
      $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); \
    end \
  end
module dsd_decode_unit_tb_top;
  import dsd_pkg::*;
  localparam logic [31:0] PC0 = 32'h1000;
  // Clock, reset and counters
  logic mclk = 1'b0;
  logic rst = 1'b1;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  // Instruction side
  logic instrValid = 1'b0;
  logic [15:0] instrWord = 16'h0;
  logic [31:0] instrPc = 32'h0;
  logic instrReady, branchValid, illegalPulse, memReq, memAck, pready, pslverr;
  dsd_br_t branchReq;
  dsd_mreq_t memCmd;
  logic [31:0] memRdata, prdata, lastWrAddr, lastWrData;
  logic [3:0] waitCycles = 4'h0; // Slows the memory when raised
  // APB master side
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  // Results of the last transfer
  logic brSeen, illSeen, rdErr;
  dsd_br_t brCap;
  logic [31:0] rdData;
  // Code tables for the control register family
  logic [7:0] ldcLo [3] = '{8'h5E, 8'h7E, 8'h6E};
  logic [7:0] stcLo [3] = '{8'h52, 8'h72, 8'h62};
  logic [7:0] stmLo [3] = '{8'h53, 8'h73, 8'h63};
  logic [31:0] stmData [3] = '{32'hFFFFFC09, 32'h7FFFFF02, 32'hFFFFFC09};
  always #20 mclk = ~mclk;
  dsd_decode_unit #(.DSP_BUILT(1'b1)) dsd_decode_unit_inst (.mclk, .rst, .instrValid,
    .instrWord, .instrPc, .instrReady, .branchValid, .branchReq, .illegalPulse, .memReq,
    .memCmd, .memAck, .memRdata, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  dsd_mem_model dsd_mem_model_inst (.mclk, .rst, .memReq, .memCmd, .memAck, .memRdata,
    .waitCycles, .lastWrAddr, .lastWrData);
  // Verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      finish_test();
    end
  end
  // One APB transfer; idle edge after it so psel never toggles in one step
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only the hang guard ends a wait that never sees ready
    do
      @(posedge mclk);
    while (pready !== 1'b1);
    rdData = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic chkReg(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rdData, e)
  endtask
  task automatic gpr(input logic [3:0] n, input logic [31:0] e);
    chkReg(A_GPR + {2'b00, n, 2'b00}, e);
  endtask
  // Issue one word, count cycles until ready returns; zero skips the count
  task automatic run(input logic [15:0] w, input logic [31:0] pc, input int expCyc);
    int n;
    instrWord <= w;
    instrPc <= pc;
    instrValid <= 1'b1;
    brSeen = 1'b0;
    illSeen = 1'b0;
    n = 1;
    @(posedge mclk);
    instrValid <= 1'b0;
    forever
    begin
      #1;
      if (branchValid === 1'b1)
      begin
        brSeen = 1'b1;
        brCap = branchReq;
      end
      if (illegalPulse === 1'b1)
        illSeen = 1'b1;
      if (instrReady === 1'b1)
        break;
      @(posedge mclk);
      n++;
    end
    if (expCyc > 0)
      `CHK(n, expCyc)
    @(posedge mclk);
  endtask
  task automatic endTest(input string name);
    $display("test %s done at %0t", name, $time);
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    chkReg(A_CTRL, 32'h1);
    chkReg(8'h20, 32'h0);
    `CHK(rdErr, 1'b1)
    apb(1'b1, A_GBR, 32'h10);
    chkReg(A_GBR, 32'h10);
    endTest("registers");
    run(16'h7108, PC0, 1);
    run(16'h72FC, PC0, 1);
    run(16'h321C, PC0, 1);
    gpr(4'h2, 32'h4);
    waitCycles <= 4'h3;
    run(16'h4176, PC0, 0);
    waitCycles <= 4'h0;
    run(16'h037A, PC0, 1);
    gpr(4'h3, 32'h7FFFFF02);
    run(16'h333F, PC0, 1);
    chkReg(A_SWORD, 32'h1);
    run(16'h333E, PC0, 1);
    gpr(4'h3, 32'hFFFFFC09);
    chkReg(A_SWORD, 32'h1);
    run(16'h703D, PC0, 1);
    run(16'hC9FC, PC0, 1);
    gpr(4'h0, 32'h3C);
    run(16'h2139, PC0, 1);
    gpr(4'h1, 32'h8);
    run(16'hCD1E, PC0, 0);
    `CHK({lastWrAddr, lastWrData[7:0]}, {32'h4C, 8'h12})
    endTest("alu");
    run(16'h4314, PC0, 3);
    chkReg(A_SWORD, 32'h0C090001);
    run(16'h82A5, PC0, 3);
    chkReg(A_SWORD, 32'h00A50001);
    run(16'h8CFF, PC0, 3);
    run(16'h0562, PC0, 1);
    gpr(4'h5, 32'h11FE);
    run(16'h8E80, 32'h2000, 3);
    run(16'h0672, PC0, 1);
    gpr(4'h6, 32'h2100);
    for (int i = 0; i < 3; i++)
    begin
      run({8'h43, ldcLo[i]}, PC0, 3);
      run({8'h08, stcLo[i]}, PC0, 1);
      gpr(4'h8, 32'hFFFFFC09);
    end
    run(16'h4177, PC0, 5);
    run(16'h0672, PC0, 1);
    gpr(4'h6, 32'h7FFFFF02);
    gpr(4'h1, 32'hC);
    for (int i = 0; i < 3; i++)
    begin
      run({8'h45, stmLo[i]}, PC0, 0);
      `CHK({lastWrAddr, lastWrData}, {32'h11FA - 4 * i, stmData[i]})
    end
    endTest("loop");
    run(16'h436A, PC0, 1);
    run(16'h086A, PC0, 1);
    gpr(4'h8, 32'hFFFFFC09);
    run(16'h4162, PC0, 0);
    `CHK({lastWrAddr, lastWrData}, {32'h8, 32'hFFFFFC09})
    run(16'h4266, PC0, 0);
    run(16'h096A, PC0, 1);
    gpr(4'h9, 32'h7FFFFF01);
    run(16'h42AA, PC0, 1);
    run(16'h0AAA, PC0, 1);
    gpr(4'hA, 32'h8);
    run(16'h41A2, PC0, 0);
    `CHK({lastWrAddr, lastWrData}, {32'h4, 32'h8})
    endTest("dsp");
    run(16'h8B10, PC0, 1);
    run(16'h8F10, PC0, 1);
    `CHK(brSeen, 1'b0)
    run(16'h311F, PC0, 1);
    run(16'h8B80, PC0, 3);
    `CHK(brCap, {1'b0, 32'h0F00})
    run(16'h8F02, PC0, 2);
    `CHK(brCap, {1'b1, 32'h1004})
    run(16'hA800, 32'h3000, 2);
    `CHK(brCap, {1'b1, 32'h2000})
    run(16'h0523, 32'h100, 2);
    `CHK(brCap, {1'b1, 32'h12F2})
    endTest("branch");
    apb(1'b1, A_CTRL, 32'h0);
    run(16'h8233, PC0, 1);
    `CHK(illSeen, 1'b1)
    chkReg(A_SWORD, 32'h00A50000);
    apb(1'b1, A_CTRL, 32'h1);
    run(16'h8233, PC0, 3);
    chkReg(A_SWORD, 32'h00330000);
    endTest("disable");
    finish_test();
  end
endmodule

/* dv/dsd_mem_model.sv */
// Behavioural data memory answering the decode unit's access port
`timescale 1ns/10ps
module dsd_mem_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Access port from the decode unit
  input wire logic memReq,
  input wire dsd_pkg::dsd_mreq_t memCmd,
  output logic memAck,
  output logic [31:0] memRdata,
  // Bench control and observation
  input wire logic [3:0] waitCycles,
  output logic [31:0] lastWrAddr,
  output logic [31:0] lastWrData
);
  import dsd_pkg::*;
  logic [31:0] mem [0:63]; // Aliased every 256 bytes, enough for the tests
  logic [3:0] waitCnt; // Wait states spent on the current access
  logic [31:0] word; // Word addressed by the pending command
  assign word = mem[memCmd.addr[7:2]];
  // Known pattern so that loads can be told apart
  initial
  begin
    for (int i = 0; i < 64; i++)
      mem[i] = 32'h7FFFFF00 + i;
  end
  // Answer after the chosen wait; read data is junk outside an answer
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      memAck <= 1'b0;
      waitCnt <= 4'h0;
      memRdata <= 32'h0;
      lastWrAddr <= 32'h0;
      lastWrData <= 32'h0;
    end
    else if (memReq && !memAck && waitCnt == waitCycles)
    begin
      memAck <= 1'b1;
      waitCnt <= 4'h0;
      memRdata <= memCmd.isByte ? {24'h0, word[8 * memCmd.addr[1:0] +: 8]} : word;
      if (memCmd.wr)
      begin
        lastWrAddr <= memCmd.addr;
        lastWrData <= memCmd.wdata;
        if (memCmd.isByte)
          mem[memCmd.addr[7:2]][8 * memCmd.addr[1:0] +: 8] <= memCmd.wdata[7:0];
        else
          mem[memCmd.addr[7:2]] <= memCmd.wdata;
      end
    end
    else
    begin
      // Toggle so a stale value is never mistaken for an answer
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReq && !memAck)
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule

/* rtl/dsd_decode_unit.sv */
// DSP-support instruction decode and execute unit with APB view
//
// Behaviour
// - immediate loop tally sets bits 16-23, clears 24-27
// - register loop tally copies low 12 bits
// - loop tally load encodings, three cycles each
// - loop begin address from pc-relative displacement
// - loop finish address from pc-relative displacement
// - register copy into control registers, three cycles
// - memory load control register, post-increment, five cycles
// - control register to general register, one cycle
// - pre-decrement store of control register, two cycles
// - DSP status load from register or memory
// - DSP status to register or memory
// - Y operand registers to register or memory
// - accumulator and X/Y moves, one cycle each
// - add immediate and add register
// - add with carry through condition flag
// - add sets flag on signed overflow
// - AND immediate into register zero, AND register
// - byte read-modify-write AND at base pointer
// - branch if false, three or one cycles
// - delayed branch if false, two or one
// - unconditional delayed pc-relative jump, two cycles
// - register-relative delayed jump, two cycles
`timescale 1ns/10ps
module dsd_decode_unit #(
  parameter bit DSP_BUILT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Instruction issue from fetch
  input wire logic instrValid,
  input wire logic [15:0] instrWord,
  input wire logic [31:0] instrPc,
  output logic instrReady,
  // Branch request and illegal report to fetch
  output logic branchValid,
  output dsd_pkg::dsd_br_t branchReq,
  output logic illegalPulse,
  // Data memory port
  output logic memReq,
  output dsd_pkg::dsd_mreq_t memCmd,
  input wire logic memAck,
  input wire logic [31:0] memRdata,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import dsd_pkg::*;

  // Architectural state
  logic [31:0] gpr_r [16]; // General registers
  logic [31:0] ctl_r [3]; // Ring bounds, loop begin, loop finish
  logic [31:0] dsp_r [6]; // DSP status, accumulator, X and Y operands
  logic [31:0] sword_r; // Status word, flag in bit 0
  logic [31:0] gbr_r; // Global base pointer, software written
  logic dspEn_r; // Extension enable
  // Sequencer state
  dsd_st_t st_r;
  logic [2:0] hold_r; // Remaining occupancy cycles
  dsd_op_t tgtOp_r; // Operation waiting on memory
  logic [3:0] tgtIdx_r; // Register index waiting on memory
  logic [7:0] tgtImm_r; // Mask for byte read-modify-write
  logic [31:0] prdata_r;

  // Index field is a control register
  function automatic logic isCtl(input logic [3:0] ix);
    return ix >= CTL_FIRST && ix <= CTL_LAST;
  endfunction

  // Index field is a DSP register
  function automatic logic isDsp(input logic [3:0] ix);
    return ix >= DSP_FIRST && ix <= DSP_LAST;
  endfunction

  // Control register slot from index
  function automatic logic [1:0] ctlSel(input logic [3:0] ix);
    logic [3:0] t;
    t = ix - CTL_FIRST;
    return t[1:0];
  endfunction

  // DSP register slot from index
  function automatic logic [2:0] dspSel(input logic [3:0] ix);
    logic [3:0] t;
    t = ix - DSP_FIRST;
    return t[2:0];
  endfunction

  // Instruction decode; unknown codes fall to illegal
  function automatic dsd_dec_t decode(input logic [15:0] w);
    dsd_dec_t d;
    logic [3:0] ix;
    logic [3:0] lo;
    d = '{op: OP_ILL, cost: CYC_ONE, dsp: 1'b0};
    ix = w[7:4];
    lo = w[3:0];
    case (w[15:12])
      PFX_SYS4:
      begin
        if (w[7:0] == LO_LOAD_LOOP_TALLY) d = '{OP_LOAD_LOOP_TALLY_R, CYC_THREE, 1'b1};
        else if (isCtl(ix) && lo == LO_LDC_R) d = '{OP_LDC_R, CYC_THREE, 1'b1};
        else if (isCtl(ix) && lo == LO_LDC_M) d = '{OP_LDC_M, CYC_FIVE, 1'b1};
        else if (isCtl(ix) && lo == LO_STC_M) d = '{OP_STC_M, CYC_TWO, 1'b1};
        else if (isDsp(ix) && lo == LO_LDS_R) d = '{OP_LDS_R, CYC_ONE, 1'b1};
        else if (isDsp(ix) && lo == LO_LDS_M) d = '{OP_LDS_M, CYC_ONE, 1'b1};
        else if (isDsp(ix) && lo == LO_STS_M) d = '{OP_STS_M, CYC_ONE, 1'b1};
      end
      PFX_SYS0:
      begin
        if (w[7:0] == LO_REGISTER_RELATIVE_JUMP) d = '{OP_REGISTER_RELATIVE_JUMP, CYC_TWO, 1'b0};
        else if (isCtl(ix) && lo == LO_STC_R) d = '{OP_STC_R, CYC_ONE, 1'b1};
        else if (isDsp(ix) && lo == LO_STS_R) d = '{OP_STS_R, CYC_ONE, 1'b1};
      end
      PFX_ADDI: d = '{OP_ADD_I, CYC_ONE, 1'b0};
      PFX_ALU3:
      begin
        if (lo == LO_ADD) d = '{OP_ADD_R, CYC_ONE, 1'b0};
        else if (lo == LO_ADD_WITH_CARRY) d = '{OP_ADD_WITH_CARRY, CYC_ONE, 1'b0};
        else if (lo == LO_ADD_OVERFLOW_CHECK) d = '{OP_ADD_OVERFLOW_CHECK, CYC_ONE, 1'b0};
      end
      PFX_ALU2:
      begin
        if (lo == LO_AND) d = '{OP_AND_R, CYC_ONE, 1'b0};
      end
      PFX_BRA: d = '{OP_BRA, CYC_TWO, 1'b0};
      PFX_HI8:
      begin
        if (w[15:8] == HI_LOAD_LOOP_TALLY) d = '{OP_LOAD_LOOP_TALLY_I, CYC_THREE, 1'b1};
        else if (w[15:8] == HI_LDRB) d = '{OP_LDR_B, CYC_THREE, 1'b1};
        else if (w[15:8] == HI_LDRF) d = '{OP_LDR_F, CYC_THREE, 1'b1};
        else if (w[15:8] == HI_BF) d = '{OP_BF, CYC_THREE, 1'b0};
        else if (w[15:8] == HI_BFS) d = '{OP_BFS, CYC_TWO, 1'b0};
      end
      PFX_HIC:
      begin
        if (w[15:8] == HI_ANDI) d = '{OP_AND_I, CYC_ONE, 1'b0};
        else if (w[15:8] == HI_ANDB) d = '{OP_AND_B, CYC_THREE, 1'b0};
      end
      default: d = '{op: OP_ILL, cost: CYC_ONE, dsp: 1'b0};
    endcase
    return d;
  endfunction

  // Issue-side combinational view
  dsd_dec_t dec;
  logic accept; // Instruction taken this edge
  logic ill; // Word not executable, whether taken or not
  logic doOp; // Taken and executed
  logic tFlag;
  logic taken; // Branch redirects fetch
  logic [31:0] rn, rm, r0;
  logic [7:0] imm8;
  logic [31:0] sx8, zx8;
  logic [32:0] addcSum;
  logic [31:0] addSum;
  logic addvOvf;
  logic [31:0] brTarget;
  logic [31:0] loopAddr;
  logic [2:0] cost;

  always_comb
  begin
    dec = decode(instrWord);
    instrReady = (st_r == ST_IDLE) && (hold_r == 3'h0);
    accept = instrValid && instrReady;
    // Without the extension the DSP codes trap like any unknown code
    ill = (dec.op == OP_ILL) || (dec.dsp && !(DSP_BUILT && dspEn_r));
    doOp = accept && !ill;
    tFlag = sword_r[SW_T];
    rn = gpr_r[instrWord[11:8]];
    rm = gpr_r[instrWord[7:4]];
    r0 = gpr_r[0];
    imm8 = instrWord[7:0];
    sx8 = {{24{imm8[7]}}, imm8};
    zx8 = {24'h0, imm8};
    addcSum = {1'b0, rn} + {1'b0, rm} + {32'h0, tFlag};
    addSum = rn + rm;
    // Overflow when like-signed operands give a sum of the other sign
    addvOvf = (rn[31] == rm[31]) && (addSum[31] != rn[31]);
    // Loop address displacement is unsigned halfwords
    loopAddr = instrPc + {23'h0, imm8, 1'b0};
    taken = ((dec.op == OP_BF || dec.op == OP_BFS) && !tFlag)
      || dec.op == OP_BRA || dec.op == OP_REGISTER_RELATIVE_JUMP;
    case (dec.op)
      OP_BRA: brTarget = instrPc + {{19{instrWord[11]}}, instrWord[11:0], 1'b0};
      OP_REGISTER_RELATIVE_JUMP: brTarget = instrPc + rn;
      default: brTarget = instrPc + {sx8[30:0], 1'b0};
    endcase
    // Untaken conditional branches and traps cost one cycle
    if (ill || ((dec.op == OP_BF || dec.op == OP_BFS) && !taken)) cost = CYC_ONE;
    else cost = dec.cost;
  end

  // Occupancy counter: fetch sees ready low while it runs
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst) hold_r <= 3'h0;
    else if (accept) hold_r <= cost - CYC_ONE;
    else if (hold_r != 3'h0) hold_r <= hold_r - 3'h1;
  end

  // General register writes, all at the accept edge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 16; i++) gpr_r[i] <= '0;
    end
    else if (doOp)
    begin
      case (dec.op)
        OP_ADD_I: gpr_r[instrWord[11:8]] <= rn + sx8;
        OP_ADD_R: gpr_r[instrWord[11:8]] <= addSum;
        OP_ADD_WITH_CARRY: gpr_r[instrWord[11:8]] <= addcSum[31:0];
        OP_ADD_OVERFLOW_CHECK: gpr_r[instrWord[11:8]] <= addSum;
        OP_AND_I: gpr_r[0] <= r0 & zx8;
        OP_AND_R: gpr_r[instrWord[11:8]] <= rn & rm;
        OP_STC_R: gpr_r[instrWord[11:8]] <= ctl_r[ctlSel(instrWord[7:4])];
        OP_STS_R: gpr_r[instrWord[11:8]] <= dsp_r[dspSel(instrWord[7:4])];
        // Post-increment of the source pointer
        OP_LDC_M, OP_LDS_M: gpr_r[instrWord[11:8]] <= rn + STEP;
        // Pre-decrement of the destination pointer
        OP_STC_M, OP_STS_M: gpr_r[instrWord[11:8]] <= rn - STEP;
        default: ;
      endcase
    end
  end

  // Control registers: register copy, pc-relative load, memory load
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 3; i++) ctl_r[i] <= '0;
    end
    else if (doOp && dec.op == OP_LDC_R) ctl_r[ctlSel(instrWord[7:4])] <= rn;
    else if (doOp && dec.op == OP_LDR_B) ctl_r[CSEL_RS] <= loopAddr;
    else if (doOp && dec.op == OP_LDR_F) ctl_r[CSEL_RE] <= loopAddr;
    else if (st_r == ST_RD && memAck && tgtOp_r == OP_LDC_M)
      ctl_r[ctlSel(tgtIdx_r)] <= memRdata;
  end

  // DSP registers: register copy and memory load
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 6; i++) dsp_r[i] <= '0;
    end
    else if (doOp && dec.op == OP_LDS_R) dsp_r[dspSel(instrWord[7:4])] <= rn;
    else if (st_r == ST_RD && memAck && tgtOp_r == OP_LDS_M)
      dsp_r[dspSel(tgtIdx_r)] <= memRdata;
  end

  // Status word: loop tally field and condition flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst) sword_r <= '0;
    else if (doOp)
    begin
      case (dec.op)
        OP_LOAD_LOOP_TALLY_R: sword_r[SW_RC_LO +: RC_W] <= rn[RC_W-1:0];
        // Upper tally bits are cleared so a short count cannot inherit a long one
        OP_LOAD_LOOP_TALLY_I: sword_r[SW_RC_LO +: RC_W] <= {{(RC_W-RC_IMM_W){1'b0}}, imm8};
        OP_ADD_WITH_CARRY: sword_r[SW_T] <= addcSum[32];
        OP_ADD_OVERFLOW_CHECK: sword_r[SW_T] <= addvOvf;
        default: ;
      endcase
    end
  end

  // Memory sequencer: one read, one write, or read then write
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r <= ST_IDLE;
      memCmd <= '0;
      tgtOp_r <= OP_ILL;
      tgtIdx_r <= 4'h0;
      tgtImm_r <= 8'h00;
    end
    else
    begin
      case (st_r)
        ST_IDLE:
        begin
          if (doOp)
          begin
            tgtOp_r <= dec.op;
            tgtIdx_r <= instrWord[7:4];
            tgtImm_r <= imm8;
            case (dec.op)
              OP_LDC_M, OP_LDS_M:
              begin
                st_r <= ST_RD;
                memCmd <= '{wr: 1'b0, isByte: 1'b0, addr: rn, wdata: '0};
              end
              OP_STC_M:
              begin
                st_r <= ST_WR;
                memCmd <= '{1'b1, 1'b0, rn - STEP, ctl_r[ctlSel(instrWord[7:4])]};
              end
              OP_STS_M:
              begin
                st_r <= ST_WR;
                memCmd <= '{1'b1, 1'b0, rn - STEP, dsp_r[dspSel(instrWord[7:4])]};
              end
              OP_AND_B:
              begin
                st_r <= ST_RD;
                memCmd <= '{1'b0, 1'b1, r0 + gbr_r, '0};
              end
              default: ;
            endcase
          end
        end
        ST_RD:
        begin
          if (memAck && tgtOp_r == OP_AND_B)
          begin
            // Write back to the same byte address
            st_r <= ST_WR;
            memCmd.wr <= 1'b1;
            memCmd.wdata <= {24'h0, memRdata[7:0] & tgtImm_r};
          end
          else if (memAck) st_r <= ST_IDLE;
        end
        ST_WR:
        begin
          if (memAck) st_r <= ST_IDLE;
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign memReq = st_r != ST_IDLE;

  // Branch and trap reports, one-cycle pulses
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      branchValid <= 1'b0;
      branchReq <= '0;
      illegalPulse <= 1'b0;
    end
    else
    begin
      branchValid <= doOp && taken;
      illegalPulse <= accept && ill;
      if (doOp && taken)
      begin
        // Plain false-branch has no delay slot
        branchReq.delayed <= dec.op != OP_BF;
        branchReq.target <= brTarget;
      end
    end
  end

  // APB decode: mapped if a known word address
  function automatic logic apbHit(input logic [7:0] a);
    return a == A_CTRL || a == A_SWORD || a == A_GBR || a == A_INFO
      || (a >= A_GPR && a <= A_GPR_END && a[1:0] == 2'h0);
  endfunction

  // APB software registers; writes land on the access edge
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      dspEn_r <= CTRL_DSP_RST;
      gbr_r <= '0;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == A_CTRL) dspEn_r <= pwdata[CTRL_DSP_EN];
      if (paddr == A_GBR) gbr_r <= pwdata;
    end
  end

  // Read data is captured in the setup cycle so it is stable in access
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst) prdata_r <= '0;
    else if (psel && !penable && !pwrite)
    begin
      if (paddr == A_CTRL) prdata_r <= {31'h0, dspEn_r};
      else if (paddr == A_SWORD) prdata_r <= sword_r;
      else if (paddr == A_GBR) prdata_r <= gbr_r;
      else if (paddr == A_INFO) prdata_r <= {27'h0, hold_r, st_r};
      else if (apbHit(paddr)) prdata_r <= gpr_r[paddr[5:2]];
      else prdata_r <= '0;
    end
  end

  assign prdata = prdata_r;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !apbHit(paddr);

  // Checks and coverage
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  chk_tally_imm: assert property (doOp && dec.op == OP_LOAD_LOOP_TALLY_I |=>
    sword_r[SW_RC_LO +: RC_W] == {4'h0, $past(imm8)})
    else $error("immediate loop tally wrong");
  chk_tally_reg: assert property (doOp && dec.op == OP_LOAD_LOOP_TALLY_R |=>
    sword_r[SW_RC_LO +: RC_W] == $past(rn[RC_W-1:0]))
    else $error("register loop tally wrong");
  chk_three_busy: assert property (doOp && dec.cost == CYC_THREE && !dec.op[4] |=>
    !instrReady ##1 !instrReady ##1 instrReady)
    else $error("three-cycle occupancy wrong");
  chk_loop_begin: assert property (doOp && dec.op == OP_LDR_B |=>
    ctl_r[CSEL_RS] == $past(instrPc) + {23'h0, $past(imm8), 1'b0})
    else $error("loop begin address wrong");
  chk_loop_finish: assert property (doOp && dec.op == OP_LDR_F |=>
    ctl_r[CSEL_RE] == $past(instrPc) + {23'h0, $past(imm8), 1'b0})
    else $error("loop finish address wrong");
  chk_ctl_postinc: assert property (doOp && dec.op == OP_LDC_M |=>
    memReq && !memCmd.wr && memCmd.addr + STEP == gpr_r[$past(instrWord[11:8])])
    else $error("post-increment load wrong");
  chk_ctl_predec: assert property (doOp && dec.op == OP_STC_M |=>
    memReq && memCmd.wr && memCmd.addr == $past(rn) - STEP)
    else $error("pre-decrement store wrong");
  chk_carry_flag: assert property (doOp && dec.op == OP_ADD_WITH_CARRY |=>
    // Carry rebuilt from operand signs and the written sum, not the adder
    sword_r[SW_T] == (($past(rn[31]) && $past(rm[31])) || (($past(rn[31]) || $past(rm[31]))
      && !gpr_r[$past(instrWord[11:8])][31])))
    else $error("carry flag wrong");
  chk_false_branch: assert property (doOp && dec.op == OP_BF && !tFlag |=>
    branchValid && !branchReq.delayed ##1 !instrReady ##1 instrReady)
    else $error("false branch wrong");
  chk_trap_nodsp: assert property (accept && dec.dsp && !dspEn_r |=>
    illegalPulse && !branchValid && instrReady)
    else $error("disabled extension not trapped");

  cov_tally: cover property (doOp && dec.op == OP_LOAD_LOOP_TALLY_I);
  cov_and_byte: cover property (doOp && dec.op == OP_AND_B ##[1:20] st_r == ST_WR);
  cov_delayed: cover property (branchValid && branchReq.delayed);
  cov_trap: cover property (illegalPulse);
endmodule

/* rtl/dsd_pkg.sv */
// Constants, opcodes and carrier types for the DSP-support decode unit
package dsd_pkg;
  // Data path width and pointer step
  localparam int XLEN = 32;
  localparam logic [31:0] STEP = 32'h4;

  // Operation classes, binary coded
  typedef enum logic [4:0] {
    OP_ILL = 5'b00000, OP_LOAD_LOOP_TALLY_R = 5'b00001, OP_LOAD_LOOP_TALLY_I = 5'b00010,
    OP_LDR_B = 5'b00011, OP_LDR_F = 5'b00100, OP_LDC_R = 5'b00101,
    OP_LDC_M = 5'b00110, OP_STC_R = 5'b00111, OP_STC_M = 5'b01000,
    OP_LDS_R = 5'b01001, OP_LDS_M = 5'b01010, OP_STS_R = 5'b01011,
    OP_STS_M = 5'b01100, OP_ADD_I = 5'b01101, OP_ADD_R = 5'b01110,
    OP_ADD_WITH_CARRY = 5'b01111, OP_ADD_OVERFLOW_CHECK = 5'b10000, OP_AND_I = 5'b10001,
    OP_AND_R = 5'b10010, OP_AND_B = 5'b10011, OP_BF = 5'b10100,
    OP_BFS = 5'b10101, OP_BRA = 5'b10110, OP_REGISTER_RELATIVE_JUMP = 5'b10111
  } dsd_op_t;

  // Memory sequencer states
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_RD = 2'b01, ST_WR = 2'b10} dsd_st_t;

  // Decoded instruction
  typedef struct packed {dsd_op_t op; logic [2:0] cost; logic dsp;} dsd_dec_t;
  // Memory command
  typedef struct packed {logic wr; logic isByte; logic [31:0] addr; logic [31:0] wdata;} dsd_mreq_t;
  // Branch request to fetch
  typedef struct packed {logic delayed; logic [31:0] target;} dsd_br_t;

  // Opcode prefixes and fixed fields
  localparam logic [3:0] PFX_SYS4 = 4'h4, PFX_SYS0 = 4'h0, PFX_ADDI = 4'h7;
  localparam logic [3:0] PFX_ALU3 = 4'h3, PFX_ALU2 = 4'h2, PFX_BRA = 4'hA;
  localparam logic [3:0] PFX_HI8 = 4'h8, PFX_HIC = 4'hC;
  localparam logic [7:0] HI_LOAD_LOOP_TALLY = 8'h82, HI_LDRB = 8'h8C, HI_LDRF = 8'h8E;
  localparam logic [7:0] HI_BF = 8'h8B, HI_BFS = 8'h8F, HI_ANDI = 8'hC9, HI_ANDB = 8'hCD;
  localparam logic [7:0] LO_LOAD_LOOP_TALLY = 8'h14, LO_REGISTER_RELATIVE_JUMP = 8'h23;
  localparam logic [3:0] LO_LDC_R = 4'hE, LO_LDC_M = 4'h7, LO_STC_R = 4'h2, LO_STC_M = 4'h3;
  localparam logic [3:0] LO_LDS_R = 4'hA, LO_LDS_M = 4'h6, LO_STS_R = 4'hA, LO_STS_M = 4'h2;
  localparam logic [3:0] LO_ADD = 4'hC, LO_ADD_WITH_CARRY = 4'hE, LO_ADD_OVERFLOW_CHECK = 4'hF, LO_AND = 4'h9;
  // Register index field: control 5..7, DSP 6..11
  localparam logic [3:0] CTL_FIRST = 4'h5, CTL_LAST = 4'h7, DSP_FIRST = 4'h6, DSP_LAST = 4'hB;
  localparam logic [1:0] CSEL_RS = 2'h1, CSEL_RE = 2'h2;

  // Status word fields
  localparam int SW_T = 0, SW_RC_LO = 16, RC_W = 12, RC_IMM_W = 8;

  // Cycle costs
  localparam logic [2:0] CYC_ONE = 3'h1, CYC_TWO = 3'h2, CYC_THREE = 3'h3, CYC_FIVE = 3'h5;

  // APB map and reset values
  localparam logic [7:0] A_CTRL = 8'h00, A_SWORD = 8'h04, A_GBR = 8'h08, A_INFO = 8'h0C;
  localparam logic [7:0] A_GPR = 8'h40, A_GPR_END = 8'h7C;
  localparam int CTRL_DSP_EN = 0;
  localparam logic CTRL_DSP_RST = 1'b1;
endpackage
